// ===== src/sos_pkg.sv
// shared constants and types for the shutter output select and trigger block
package sos_pkg;

    // =====================================================
    // serial frame layout
    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam int FRAME_BITS = ADDR_W + DATA_W;

    // =====================================================
    // register offsets
    localparam logic [7:0] OUT_SRC_SEL_ADDR = 8'h60;
    localparam logic [7:0] TRIGGER_ADDR = 8'h61;

    // =====================================================
    // selector field positions and reset values
    localparam int SEL_W = 3;
    localparam int SUBSTRATE_SEL_LSB = 0;
    localparam int MECH_SEL_LSB = 3;
    localparam int STROBE_SEL_LSB = 6;
    localparam int TEST_SEL_LSB = 9;
    localparam int OUT_SRC_SEL_W = 12;
    localparam logic [2:0] SUBSTRATE_SEL_RST = 3'h0;
    localparam logic [2:0] MECH_SEL_RST = 3'h1;
    localparam logic [2:0] STROBE_SEL_RST = 3'h2;
    localparam logic [2:0] TEST_SEL_RST = 3'h3;

    // selector codes
    localparam logic [2:0] SRC_SHUTTER_GEN_0 = 3'h0;
    localparam logic [2:0] SRC_SHUTTER_GEN_1 = 3'h1;
    localparam logic [2:0] SRC_SHUTTER_GEN_2 = 3'h2;
    localparam logic [2:0] SRC_SHUTTER_GEN_3 = 3'h3;
    localparam logic [2:0] SRC_COMB0 = 3'h4;
    localparam logic [2:0] SRC_COMB1 = 3'h5;
    localparam logic [2:0] SRC_INVALID = 3'h6;
    localparam logic [2:0] SRC_PAIR = 3'h7;

    // =====================================================
    // trigger field positions
    localparam int TRIG_W = 8;
    localparam logic [7:0] TRIGGER_RST = 8'h00;
    localparam int TRIG_SHUT_LSB = 0;
    localparam int TRIG_BIAS_LSB = 4;
    localparam int TRIG_EXPOSURE = 6;
    localparam int TRIG_READOUT = 7;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sos_write_t;

    typedef struct packed {
        logic [SEL_W-1:0] test;
        logic [SEL_W-1:0] strobe;
        logic [SEL_W-1:0] mech;
        logic [SEL_W-1:0] substrate;
    } sos_sel_t;

endpackage : sos_pkg

// ===== src/sos_serial_rx.sv
// three-wire serial write receiver for the configuration port
`timescale 1ns/10ps
module sos_serial_rx (
    input wire logic mclk,
    input wire logic rstB,
    input wire logic serLoadB,
    input wire logic serClk,
    input wire logic serData,
    output logic wrValid,
    output sos_pkg::sos_write_t wrWord
);

    // =====================================================
    // pin synchronisers
    logic [1:0] loadSync_q;
    logic [1:0] clkSync_q;
    logic [1:0] dataSync_q;
    logic loadPrev_q;
    logic clkPrev_q;

    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            loadSync_q <= 2'h3;
            clkSync_q <= 2'h0;
            dataSync_q <= 2'h0;
            loadPrev_q <= 1'b1;
            clkPrev_q <= 1'b0;
        end else begin
            loadSync_q <= {loadSync_q[0], serLoadB};
            clkSync_q <= {clkSync_q[0], serClk};
            dataSync_q <= {dataSync_q[0], serData};
            loadPrev_q <= loadSync_q[1];
            clkPrev_q <= clkSync_q[1];
        end
    end

    logic clkRise;
    logic frameEnd;
    assign clkRise = clkSync_q[1] & ~clkPrev_q & ~loadSync_q[1];
    assign frameEnd = loadSync_q[1] & ~loadPrev_q;

    // =====================================================
    // shift in, lsb first: address then data
    logic [sos_pkg::FRAME_BITS-1:0] shift_q;
    logic [5:0] count_q;

    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            shift_q <= '0;
            count_q <= 6'h00;
        end else if (frameEnd) begin
            count_q <= 6'h00;
        end else if (clkRise) begin
            shift_q <= {dataSync_q[1], shift_q[sos_pkg::FRAME_BITS-1:1]};
            // saturate so an overlong frame is recognised and dropped
            if (count_q != 6'h3f) begin
                count_q <= count_q + 6'h01;
            end
        end
    end

    // short or long frames are discarded whole
    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            wrValid <= 1'b0;
            wrWord <= '0;
        end else begin
            wrValid <= frameEnd && (count_q == 6'(sos_pkg::FRAME_BITS));
            if (frameEnd) begin
                wrWord.addr <= shift_q[sos_pkg::ADDR_W-1:0];
                wrWord.data <= shift_q[sos_pkg::FRAME_BITS-1:sos_pkg::ADDR_W];
            end
        end
    end

endmodule : sos_serial_rx

// ===== src/sos_shutter_ctrl.sv
// shutter output source selectors and exposure/readout trigger register
`timescale 1ns/10ps
module sos_shutter_ctrl (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic serLoadB,
    input wire logic serClk,
    input wire logic serData,
    input wire logic verticalSync,
    input wire logic [3:0] shutterGen,
    input wire logic substrateComb0,
    input wire logic substrateComb1,
    input wire logic shutterPairComb,
    input wire logic exposureDone,
    input wire logic readoutDone,
    output logic substrateBiasPin,
    output logic mechShutterPin,
    output logic strobePin,
    output logic testOutPin,
    output logic [3:0] shutterGenStart,
    output logic [1:0] biasGenStart,
    output logic exposureStart,
    output logic readoutStart,
    output logic exposureBusy,
    output logic readoutBusy,
    output sos_pkg::sos_sel_t activeSel,
    output logic [7:0] activeTrigger
);

    // =====================================================
    // reset release
    logic [1:0] rstSync_q;
    logic rstB;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstB = rstSync_q[1];

    // =====================================================
    // serial port
    logic wrValid;
    sos_pkg::sos_write_t wrWord;

    sos_serial_rx u_rx (
        .mclk(mclk),
        .rstB(rstB),
        .serLoadB(serLoadB),
        .serClk(serClk),
        .serData(serData),
        .wrValid(wrValid),
        .wrWord(wrWord)
    );

    logic selWrite;
    logic trigWrite;
    assign selWrite = wrValid && (wrWord.addr == sos_pkg::OUT_SRC_SEL_ADDR);
    assign trigWrite = wrValid && (wrWord.addr == sos_pkg::TRIGGER_ADDR);

    // =====================================================
    // vertical sync edge
    logic [1:0] vsSync_q;
    logic vsPrev_q;
    logic vsEdge;

    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            vsSync_q <= 2'h0;
            vsPrev_q <= 1'b0;
        end else begin
            vsSync_q <= {vsSync_q[0], verticalSync};
            vsPrev_q <= vsSync_q[1];
        end
    end
    assign vsEdge = vsSync_q[1] & ~vsPrev_q;

    // =====================================================
    // staging registers
    localparam sos_pkg::sos_sel_t SEL_RST = '{
        test: sos_pkg::TEST_SEL_RST,
        strobe: sos_pkg::STROBE_SEL_RST,
        mech: sos_pkg::MECH_SEL_RST,
        substrate: sos_pkg::SUBSTRATE_SEL_RST
    };

    sos_pkg::sos_sel_t selStage_q;
    logic selPend_q;
    logic [7:0] trigStage_q;
    logic trigPend_q;

    // a write landing on the sync edge stays pending for the next one
    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            selStage_q <= SEL_RST;
            selPend_q <= 1'b0;
        end else if (selWrite) begin
            selStage_q <= wrWord.data[sos_pkg::OUT_SRC_SEL_W-1:0];
            selPend_q <= 1'b1;
        end else if (vsEdge) begin
            selPend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            trigStage_q <= sos_pkg::TRIGGER_RST;
            trigPend_q <= 1'b0;
        end else if (trigWrite) begin
            trigStage_q <= wrWord.data[sos_pkg::TRIG_W-1:0];
            trigPend_q <= 1'b1;
        end else if (vsEdge) begin
            trigPend_q <= 1'b0;
        end
    end

    // =====================================================
    // applied values
    logic trigApply;
    assign trigApply = vsEdge && trigPend_q && !trigWrite;

    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            activeSel <= SEL_RST;
        end else if (vsEdge && selPend_q && !selWrite) begin
            activeSel <= selStage_q;
        end
    end

    // the applied trigger reads back until the next applied write
    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            activeTrigger <= sos_pkg::TRIGGER_RST;
        end else if (trigApply) begin
            activeTrigger <= trigStage_q;
        end
    end

    // =====================================================
    // launch pulses
    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            shutterGenStart <= 4'h0;
            biasGenStart <= 2'h0;
        end else begin
            shutterGenStart <= trigApply ? trigStage_q[sos_pkg::TRIG_SHUT_LSB +: 4] : 4'h0;
            biasGenStart <= trigApply ? trigStage_q[sos_pkg::TRIG_BIAS_LSB +: 2] : 2'h0;
        end
    end

    // =====================================================
    // exposure then readout sequencing
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_EXPOSE,
        SEQ_READOUT
    } sos_seq_t;

    sos_seq_t seq_q;
    logic readAfter_q;
    logic wantExp;
    logic wantRead;
    assign wantExp = trigApply && trigStage_q[sos_pkg::TRIG_EXPOSURE];
    assign wantRead = trigApply && trigStage_q[sos_pkg::TRIG_READOUT];

    // new exposure and readout requests are ignored while a sequence is running
    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            seq_q <= SEQ_IDLE;
            readAfter_q <= 1'b0;
            exposureStart <= 1'b0;
            readoutStart <= 1'b0;
        end else begin
            exposureStart <= 1'b0;
            readoutStart <= 1'b0;
            case (seq_q)
                SEQ_IDLE: begin
                    if (wantExp) begin
                        exposureStart <= 1'b1;
                        readAfter_q <= wantRead;
                        seq_q <= SEQ_EXPOSE;
                    end else if (wantRead) begin
                        readoutStart <= 1'b1;
                        seq_q <= SEQ_READOUT;
                    end
                end
                SEQ_EXPOSE: begin
                    if (exposureDone) begin
                        readAfter_q <= 1'b0;
                        if (readAfter_q) begin
                            readoutStart <= 1'b1;
                            seq_q <= SEQ_READOUT;
                        end else begin
                            seq_q <= SEQ_IDLE;
                        end
                    end
                end
                SEQ_READOUT: begin
                    if (readoutDone) begin
                        seq_q <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq_q <= SEQ_IDLE;
                end
            endcase
        end
    end

    assign exposureBusy = (seq_q == SEQ_EXPOSE);
    assign readoutBusy = (seq_q == SEQ_READOUT);

    // =====================================================
    // output source selection
    function automatic logic pickSource(input logic [2:0] code, input logic [3:0] shut,
                                        input logic comb0, input logic comb1, input logic pair);
        logic res;
        res = 1'b0;
        case (code)
            sos_pkg::SRC_SHUTTER_GEN_0: res = shut[0];
            sos_pkg::SRC_SHUTTER_GEN_1: res = shut[1];
            sos_pkg::SRC_SHUTTER_GEN_2: res = shut[2];
            sos_pkg::SRC_SHUTTER_GEN_3: res = shut[3];
            sos_pkg::SRC_COMB0: res = comb0;
            sos_pkg::SRC_COMB1: res = comb1;
            // invalid code parks the pin low rather than guessing
            sos_pkg::SRC_INVALID: res = 1'b0;
            sos_pkg::SRC_PAIR: res = pair;
            default: res = 1'b0;
        endcase
        return res;
    endfunction : pickSource

    // registered so pins never glitch through the mux
    always_ff @(posedge mclk or negedge rstB) begin
        if (!rstB) begin
            substrateBiasPin <= 1'b0;
            mechShutterPin <= 1'b0;
            strobePin <= 1'b0;
            testOutPin <= 1'b0;
        end else begin
            substrateBiasPin <= pickSource(activeSel.substrate, shutterGen, substrateComb0,
                                           substrateComb1, shutterPairComb);
            mechShutterPin <= pickSource(activeSel.mech, shutterGen, substrateComb0,
                                         substrateComb1, shutterPairComb);
            strobePin <= pickSource(activeSel.strobe, shutterGen, substrateComb0,
                                    substrateComb1, shutterPairComb);
            testOutPin <= pickSource(activeSel.test, shutterGen, substrateComb0,
                                     substrateComb1, shutterPairComb);
        end
    end

endmodule : sos_shutter_ctrl

// ===== test/sos_far_model.sv
// far side model: shutter and bias waveforms plus exposure and readout counters
`timescale 1ns/10ps
module sos_far_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic exposureStart,
    input wire logic readoutStart,
    input wire logic [7:0] lat,
    output logic [3:0] shutterGen,
    output logic substrateComb0,
    output logic substrateComb1,
    output logic shutterPairComb,
    output logic exposureDone,
    output logic readoutDone
);
    // =====================================
    // counter bits, so every source differs in rate
    logic [7:0] wave_q;
    logic [7:0] exp_q;
    logic [7:0] rd_q;
    assign shutterGen = wave_q[3:0];
    assign substrateComb0 = wave_q[4];
    assign substrateComb1 = wave_q[5];
    assign shutterPairComb = wave_q[6];
    assign exposureDone = exp_q == 8'h01;
    assign readoutDone = rd_q == 8'h01;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wave_q <= 8'h00;
            exp_q <= 8'h00;
            rd_q <= 8'h00;
        end else begin
            wave_q <= wave_q + 8'h01;
            // lat sets a prompt or slow answer
            exp_q <= exposureStart ? lat : ((exp_q != 8'h00) ? exp_q - 8'h01 : exp_q);
            rd_q <= readoutStart ? lat : ((rd_q != 8'h00) ? rd_q - 8'h01 : rd_q);
        end
    end
endmodule : sos_far_model

// ===== test/sos_shutter_ctrl_bench.sv
// self-checking bench for the shutter select and trigger block
`timescale 1ns/10ps
module sos_shutter_ctrl_bench;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic serLoadB = 1'b1;
    logic serClk = 1'b0;
    logic serData = 1'b0;
    logic verticalSync = 1'b0;
    logic [7:0] lat = 8'h01;
    logic [3:0] shutterGen, shutterGenStart;
    logic [1:0] biasGenStart;
    logic substrateComb0, substrateComb1, shutterPairComb, exposureDone, readoutDone;
    logic substrateBiasPin, mechShutterPin, strobePin, testOutPin;
    logic exposureStart, readoutStart, exposureBusy, readoutBusy;
    sos_pkg::sos_sel_t activeSel;
    logic [7:0] activeTrigger;
    logic [11:0] selNow = 12'h688;
    int error_cnt = 0;
    int compares = 0;
    int launches = 0;

    always #12.5 mclk = ~mclk;
    always @(posedge mclk) launches += int'(|{shutterGenStart, biasGenStart, exposureStart, readoutStart});

    sos_shutter_ctrl DUT (.mclk, .rst_b, .serLoadB, .serClk, .serData, .verticalSync, .shutterGen, .substrateComb0,
        .substrateComb1, .shutterPairComb, .exposureDone, .readoutDone, .substrateBiasPin, .mechShutterPin, .strobePin,
        .testOutPin, .shutterGenStart, .biasGenStart, .exposureStart, .readoutStart, .exposureBusy, .readoutBusy,
        .activeSel, .activeTrigger);
    sos_far_model far (.mclk, .rst_b, .exposureStart, .readoutStart, .lat, .shutterGen, .substrateComb0,
        .substrateComb1, .shutterPairComb, .exposureDone, .readoutDone);

    // =====================================
    // shared steps
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic wrReg(input logic [7:0] a, input logic [23:0] d);
        logic [31:0] f;
        f = {d, a};
        serLoadB <= 1'b0;
        for (int i = 0; i < 32; i++) begin
            serData <= f[i];
            cyc(3);
            serClk <= 1'b1;
            cyc(3);
            serClk <= 1'b0;
        end
        cyc(3);
        serLoadB <= 1'b1;
        // idle line must not echo the last bit
        serData <= ~f[31];
        cyc(10);
    endtask : wrReg

    task automatic vsync();
        verticalSync <= 1'b1;
        cyc(4);
        verticalSync <= 1'b0;
        cyc(6);
    endtask : vsync

    task automatic waitPulse();
        for (int k = 0; k < 20 && {shutterGenStart, biasGenStart, exposureStart, readoutStart} === 8'h00; k++) begin
            cyc(1);
        end
    endtask : waitPulse

    // =====================================
    // scenarios
    task automatic selScene();
        logic [2:0] codes [7];
        logic [11:0] v;
        logic [7:0] s;
        logic [3:0] e;
        logic [3:0] g;
        codes = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
        for (int i = 0; i < 7; i++) begin
            v = {codes[(i + 3) % 7], codes[(i + 2) % 7], codes[(i + 1) % 7], codes[i]};
            wrReg(sos_pkg::OUT_SRC_SEL_ADDR, {12'hfff, v});
            check("sel before sync", selNow, activeSel);
            vsync();
            selNow = v;
            check("sel after sync", v, activeSel);
            for (int j = 0; j < 16; j++) begin
                s = {shutterPairComb, 1'b0, substrateComb1, substrateComb0, shutterGen};
                e = {s[v[11:9]], s[v[8:6]], s[v[5:3]], s[v[2:0]]};
                cyc(1);
                g = {testOutPin, strobePin, mechShutterPin, substrateBiasPin};
                check("pins", {8'h00, e}, {8'h00, g});
            end
        end
        wrReg(8'h62, 24'h000fff);
        vsync();
        check("sel unmapped", selNow, activeSel);
    endtask : selScene

    task automatic trigScene();
        logic [7:0] t;
        int n;
        for (int b = 0; b < 6; b++) begin
            t = 8'h01 << b;
            n = launches;
            wrReg(sos_pkg::TRIGGER_ADDR, {16'h0000, t});
            // nothing may launch or read back before the sync edge
            check("trig before sync", {4'h0, t >> 1}, {4'h0, activeTrigger});
            check("early launch", n[11:0], launches[11:0]);
            verticalSync <= 1'b1;
            waitPulse();
            check("starts", {6'h00, t[5:0]}, {6'h00, biasGenStart, shutterGenStart});
            cyc(1);
            check("pulse end", 12'h000, {6'h00, biasGenStart, shutterGenStart});
            verticalSync <= 1'b0;
            cyc(6);
            check("trigger", {4'h0, t}, {4'h0, activeTrigger});
        end
        n = launches;
        vsync();
        check("refire", n[11:0], launches[11:0]);
    endtask : trigScene

    task automatic expScene(input logic [7:0] t, input logic [7:0] l, input logic [2:0] first);
        logic sawDone;
        sawDone = 1'b0;
        lat <= l;
        wrReg(sos_pkg::TRIGGER_ADDR, {16'h0000, t});
        verticalSync <= 1'b1;
        waitPulse();
        check("first start", {9'h000, first}, {9'h000, exposureStart, exposureBusy, readoutStart});
        verticalSync <= 1'b0;
        for (int k = 0; k < 60 && readoutStart !== 1'b1; k++) begin
            cyc(1);
            sawDone = sawDone | exposureDone;
        end
        check("readout order", {10'h000, 1'b1, t[6]}, {10'h000, readoutStart, sawDone});
        for (int k = 0; k < 60 && readoutBusy !== 1'b0; k++) begin
            cyc(1);
        end
        check("busy end", 12'h000, {10'h000, exposureBusy, readoutBusy});
        cyc(4);
    endtask : expScene

    task automatic results();
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        #500000;
        error_cnt++;
        results();
    end

    initial begin
        cyc(2);
        rst_b <= 1'b1;
        cyc(6);
        check("reset sel", 12'h688, activeSel);
        check("reset trig", 12'h000, {4'h0, activeTrigger});
        selScene();
        trigScene();
        expScene(8'hc0, 8'h14, 3'h6);
        expScene(8'h80, 8'h01, 3'h1);
        results();
    end
endmodule : sos_shutter_ctrl_bench

// ===== test/sos_shutter_ctrl_checker.sv
// assertion checker for the shutter select and trigger block
`timescale 1ns/10ps
module sos_shutter_ctrl_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic verticalSync,
    input wire logic [3:0] shutterGen,
    input wire logic substrateComb0,
    input wire logic substrateComb1,
    input wire logic shutterPairComb,
    input wire logic exposureDone,
    input wire logic readoutDone,
    input wire logic substrateBiasPin,
    input wire logic mechShutterPin,
    input wire logic strobePin,
    input wire logic testOutPin,
    input wire logic [3:0] shutterGenStart,
    input wire logic [1:0] biasGenStart,
    input wire logic exposureStart,
    input wire logic readoutStart,
    input wire logic exposureBusy,
    input wire logic readoutBusy,
    input wire sos_pkg::sos_sel_t activeSel,
    input wire logic [7:0] activeTrigger
);
    // =====================================
    // reference of the pin muxes
    logic [7:0] src;
    logic [3:0] pin_q;
    logic [1:0] rdy_q;
    logic [3:0] syncAge_q;
    // code 6 has no source, so it reads as 0
    assign src = {shutterPairComb, 1'b0, substrateComb1, substrateComb0, shutterGen};
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q <= 4'h0;
            rdy_q <= 2'h0;
            syncAge_q <= 4'hf;
        end else begin
            pin_q <= {src[activeSel.test], src[activeSel.strobe], src[activeSel.mech], src[activeSel.substrate]};
            rdy_q <= (rdy_q == 2'h3) ? rdy_q : rdy_q + 2'h1;
            syncAge_q <= verticalSync ? 4'h0 : ((syncAge_q == 4'hf) ? syncAge_q : syncAge_q + 4'h1);
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence expEnd;
        exposureBusy && exposureDone && activeTrigger[7];
    endsequence
    sequence genLaunch;
        shutterGenStart != 4'h0;
    endsequence
    sub_pin_a: assert property (rdy_q == 2'h3 |-> substrateBiasPin == pin_q[0]) else $error("substrate pin");
    mech_pin_a: assert property (rdy_q == 2'h3 |-> mechShutterPin == pin_q[1]) else $error("mech pin");
    strobe_pin_a: assert property (rdy_q == 2'h3 |-> strobePin == pin_q[2]) else $error("strobe pin");
    test_pin_a: assert property (rdy_q == 2'h3 |-> testOutPin == pin_q[3]) else $error("test pin");
    shut_map_a: assert property (genLaunch |-> (shutterGenStart & ~activeTrigger[3:0]) == 4'h0)
        else $error("gen map");
    bias_map_a: assert property (biasGenStart != 2'h0 |-> (biasGenStart & ~activeTrigger[5:4]) == 2'h0)
        else $error("bias map");
    shut_pulse_a: assert property (genLaunch |=> shutterGenStart == 4'h0) else $error("gen pulse");
    exp_busy_a: assert property (exposureStart |-> exposureBusy && activeTrigger[6])
        else $error("exposure start");
    readout_next_a: assert property (expEnd |=> readoutStart && readoutBusy) else $error("readout follow");
    readout_end_a: assert property (readoutBusy && readoutDone |=> !readoutBusy) else $error("readout end");
    sel_staged_a: assert property ($changed(activeSel) |-> syncAge_q < 4'h8) else $error("sel staged");
    trig_staged_a: assert property ($changed(activeTrigger) |-> syncAge_q < 4'h8) else $error("trig staged");
endmodule : sos_shutter_ctrl_checker

bind sos_shutter_ctrl sos_shutter_ctrl_checker chk (.mclk, .rst_b, .verticalSync, .shutterGen, .substrateComb0,
    .substrateComb1, .shutterPairComb, .exposureDone, .readoutDone, .substrateBiasPin, .mechShutterPin, .strobePin,
    .testOutPin, .shutterGenStart, .biasGenStart, .exposureStart, .readoutStart, .exposureBusy, .readoutBusy,
    .activeSel, .activeTrigger);
